//--- rtl/tmc_config_regs.v
// Configuration bank of the time measurement core: two write words,
// decoded control outputs, oscillator settle timer and status word.
// Assumes a same-clock Avalon-MM master; no pin inputs cross domains.
`timescale 1ns/1ps
`include "tmc_defines.vh"

module tmc_config_regs #(
    parameter SETTLE_SHORT_CYC = `TMC_SETTLE_SHORT_CYC,
    parameter SETTLE_LONG_CYC  = `TMC_SETTLE_LONG_CYC
) (
    input  wire        sys_clk_in,
    input  wire        resetn_in,
    input  wire        clk_en_in,
    input  wire [3:0]  avs_address_in,
    input  wire        avs_read_in,
    input  wire        avs_write_in,
    input  wire [31:0] avs_writedata_in,
    input  wire [3:0]  avs_byteenable_in,
    output reg  [31:0] avs_readdata_out,
    output reg         avs_waitrequest_out,
    output reg  [1:0]  avs_response_out,
    input  wire        meas_start_in,
    output reg         start_edge_invert_out,
    output reg         stop_a_edge_invert_out,
    output reg         stop_b_edge_invert_out,
    output reg         range_two_select_out,
    output reg         auto_cal_run_out,
    output reg         cal_calc_enable_out,
    output reg         temp_cycle_clock_select_out,
    output reg  [7:0]  temp_clk_hs_periods_out,
    output reg  [2:0]  dummy_cycles_out,
    output reg  [9:0]  temp_cycle_time_us_out,
    output reg         four_ports_out,
    output reg         fast_osc_on_out,
    output reg         fast_osc_ready_out,
    output reg  [2:0]  fast_clock_prediv_out,
    output reg  [4:0]  resonator_cal_periods_out,
    output reg  [4:0]  pulse_prediv_out,
    output reg  [3:0]  pulse_count_out,
    output reg         pulse_gen_enable_out,
    output reg  [2:0]  chan_a_hit_count_out,
    output reg         chan_a_enable_out,
    output reg  [2:0]  chan_b_hit_count_out,
    output reg         chan_b_enable_out,
    output reg         fast_init_out
);

    // Idle-ack bus states
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_ACK  = 2'b10;

    reg  [23:0] setup_q;
    reg  [23:0] hits_q;
    reg  [1:0]  state_q;
    reg  [1:0]  state_d;
    reg  [21:0] settle_cnt_q;
    reg  [1:0]  osc_mode_q;
    reg         illegal_q;
    wire [23:0] wmask;
    wire        hit_setup;
    wire        hit_hits;
    wire        hit_stat;
    wire [23:0] setup_new;
    wire [23:0] hits_new;
    wire        bad_setup;
    wire        bad_hits;
    wire        req;
    wire        take;
    wire        commit;

    // Next values of the decoded controls
    reg         start_inv_d;
    reg         stop_a_inv_d;
    reg         stop_b_inv_d;
    reg         range_two_d;
    reg         auto_cal_d;
    reg         cal_calc_d;
    reg         tclk_sel_d;
    reg  [2:0]  dummy_d;
    reg  [9:0]  temp_cycle_time_d;
    reg         four_ports_d;
    reg  [2:0]  prediv_d;
    reg  [4:0]  resonator_cal_periods_d;
    reg  [4:0]  pulse_prediv_d;
    reg  [3:0]  pulse_count_d;
    reg         pulse_en_d;
    reg  [2:0]  hit_a_d;
    reg         hit_a_en_d;
    reg  [2:0]  hit_b_d;
    reg         hit_b_en_d;
    reg         fast_init_d;

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_lane
            assign wmask[g*8 +: 8] = {8{avs_byteenable_in[g]}};
        end
    endgenerate

    assign req       = avs_read_in | avs_write_in;
    assign take      = (state_q == ST_IDLE) && req;
    // Writes land on the edge the master sees waitrequest low
    assign commit    = (state_q == ST_ACK) && avs_write_in;
    assign hit_setup = (avs_address_in == `TMC_OFS_SETUP);
    assign hit_hits  = (avs_address_in == `TMC_OFS_HITS);
    assign hit_stat  = (avs_address_in == `TMC_OFS_STATUS);
    assign setup_new = (setup_q & ~wmask) | (avs_writedata_in[23:0] & wmask);
    assign hits_new  = (hits_q & ~wmask) | (avs_writedata_in[23:0] & wmask);
    // Software-side misuse is flagged, not blocked: setup decode stays legal, hit counts over 4 reach the outputs
    assign bad_setup = (setup_new[`TMC_F_PDIV_LO +: 4] == 4'h0)
                     | (!setup_new[`TMC_B_CAL_EN]
                        && setup_new[`TMC_B_RANGE2]);
    assign bad_hits  = (hits_new[`TMC_F_HITA_LO +: 3] > 3'h4)
                     | (hits_new[`TMC_F_HITB_LO +: 3] > 3'h4);

    always @* begin
        state_d = ST_IDLE;
        case (state_q)
            ST_IDLE: state_d = req ? ST_ACK : ST_IDLE;
            ST_ACK:  state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    // One wait cycle per access; answer lands on the second edge
    always @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            state_q             <= ST_IDLE;
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out    <= 32'h0000_0000;
            avs_response_out    <= 2'h0;
            setup_q             <= `TMC_SETUP_RST;
            hits_q              <= `TMC_HITS_RST;
            illegal_q           <= 1'b0;
        end else if (clk_en_in) begin
            state_q             <= state_d;
            avs_waitrequest_out <= !take;
            // Read data taken here stands through the acknowledge edge
            if (take) begin
                avs_response_out <= (hit_setup | hit_hits | hit_stat)
                                    ? 2'h0 : 2'h2;
                // Write-only words read back as zero
                avs_readdata_out <= 32'h0000_0000;
                if (avs_read_in && hit_stat)
                    avs_readdata_out <= {29'h0, illegal_q,
                                         fast_osc_ready_out,
                                         fast_osc_on_out};
            end
            // Values hold until rewritten or reset
            if (commit && hit_setup) begin
                setup_q   <= setup_new;
                illegal_q <= bad_setup;
            end
            if (commit && hit_hits) begin
                hits_q    <= hits_new;
                illegal_q <= bad_hits;
            end
        end
    end

    // Oscillator control and settle timer; ready drops one edge after a
    // mode change, so a status read taken on that edge still reports a stale settle
    always @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            osc_mode_q         <= `TMC_OSC_ON;
            settle_cnt_q       <= 22'h0;
            fast_osc_on_out    <= 1'b0;
            fast_osc_ready_out <= 1'b0;
        end else if (clk_en_in) begin
            osc_mode_q <= setup_q[`TMC_F_OSC_LO +: 2];
            if (osc_mode_q != setup_q[`TMC_F_OSC_LO +: 2]) begin
                settle_cnt_q       <= 22'h0;
                fast_osc_ready_out <= 1'b0;
            end else begin
                case (osc_mode_q)
                    `TMC_OSC_OFF: begin
                        fast_osc_on_out    <= 1'b0;
                        fast_osc_ready_out <= 1'b0;
                    end
                    `TMC_OSC_ON: begin
                        fast_osc_on_out    <= 1'b1;
                        fast_osc_ready_out <= 1'b1;
                    end
                    default: begin
                        fast_osc_on_out <= 1'b1;
                        if (settle_cnt_q >= ((osc_mode_q ==
                                `TMC_OSC_SETTLE_S) ?
                                SETTLE_SHORT_CYC[21:0] - 22'h1 :
                                SETTLE_LONG_CYC[21:0] - 22'h1))
                            fast_osc_ready_out <= 1'b1;
                        else
                            settle_cnt_q <= settle_cnt_q + 22'h1;
                    end
                endcase
            end
        end
    end

    // Next decoded values from the stored words
    always @* begin
        start_inv_d    = setup_q[`TMC_B_START_INV];
        stop_a_inv_d   = setup_q[`TMC_B_STOPA_INV];
        stop_b_inv_d   = setup_q[`TMC_B_STOPB_INV];
        range_two_d    = setup_q[`TMC_B_RANGE2];
        auto_cal_d     = !setup_q[`TMC_B_ACAL_DIS];
        // Clear honoured only in range one
        cal_calc_d     = setup_q[`TMC_B_CAL_EN]
                         | setup_q[`TMC_B_RANGE2];
        tclk_sel_d     = setup_q[`TMC_B_TCLK_SEL];
        dummy_d        = setup_q[`TMC_B_DUMMY]
                         ? `TMC_DUMMY_LONG : `TMC_DUMMY_SHORT;
        temp_cycle_time_d       = setup_q[`TMC_B_TEMP_CYCLE_TIME]
                         ? `TMC_TCYC_LONG_US : `TMC_TCYC_SHORT_US;
        four_ports_d   = setup_q[`TMC_B_PORTS];
        case (setup_q[`TMC_F_DIV_LO +: 2])
            2'h0:    prediv_d = 3'h1;
            2'h1:    prediv_d = 3'h2;
            default: prediv_d = 3'h4;
        endcase
        resonator_cal_periods_d       = 5'h02 << setup_q[`TMC_F_RESONATOR_CAL_PERIODS_LO +: 2];
        // Zero is not permitted; clamp to divide by two
        pulse_prediv_d = (setup_q[`TMC_F_PDIV_LO +: 4] == 4'h0)
                         ? 5'h02
                         : {1'b0, setup_q[`TMC_F_PDIV_LO +: 4]} + 5'h01;
        pulse_count_d  = setup_q[`TMC_F_PCNT_LO +: 4];
        pulse_en_d     = (setup_q[`TMC_F_PCNT_LO +: 4] != 4'h0);
        hit_a_d        = hits_q[`TMC_F_HITA_LO +: 3];
        hit_a_en_d     = (hits_q[`TMC_F_HITA_LO +: 3] != 3'h0);
        hit_b_d        = hits_q[`TMC_F_HITB_LO +: 3];
        hit_b_en_d     = (hits_q[`TMC_F_HITB_LO +: 3] != 3'h0);
        fast_init_d    = hits_q[`TMC_B_FAST_INIT];
    end

    // Decoded controls; latched per measurement start
    always @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            start_edge_invert_out       <= 1'b0;
            stop_a_edge_invert_out      <= 1'b0;
            stop_b_edge_invert_out      <= 1'b0;
            range_two_select_out        <= 1'b1;
            auto_cal_run_out            <= 1'b1;
            cal_calc_enable_out         <= 1'b1;
            temp_cycle_clock_select_out <= 1'b1;
            temp_clk_hs_periods_out     <= `TMC_TCLK_HS_PER;
            dummy_cycles_out            <= `TMC_DUMMY_SHORT;
            temp_cycle_time_us_out      <= `TMC_TCYC_SHORT_US;
            four_ports_out              <= 1'b1;
            fast_clock_prediv_out       <= 3'h1;
            resonator_cal_periods_out   <= 5'h02;
            pulse_prediv_out            <= 5'h01;
            pulse_count_out             <= 4'h0;
            pulse_gen_enable_out        <= 1'b0;
            chan_a_hit_count_out        <= 3'h0;
            chan_a_enable_out           <= 1'b0;
            chan_b_hit_count_out        <= 3'h0;
            chan_b_enable_out           <= 1'b0;
            fast_init_out               <= 1'b0;
        end else if (clk_en_in && meas_start_in) begin
            start_edge_invert_out       <= start_inv_d;
            stop_a_edge_invert_out      <= stop_a_inv_d;
            stop_b_edge_invert_out      <= stop_b_inv_d;
            range_two_select_out        <= range_two_d;
            auto_cal_run_out            <= auto_cal_d;
            cal_calc_enable_out         <= cal_calc_d;
            temp_cycle_clock_select_out <= tclk_sel_d;
            temp_clk_hs_periods_out     <= `TMC_TCLK_HS_PER;
            dummy_cycles_out            <= dummy_d;
            temp_cycle_time_us_out      <= temp_cycle_time_d;
            four_ports_out              <= four_ports_d;
            fast_clock_prediv_out       <= prediv_d;
            resonator_cal_periods_out   <= resonator_cal_periods_d;
            pulse_prediv_out            <= pulse_prediv_d;
            pulse_count_out             <= pulse_count_d;
            pulse_gen_enable_out        <= pulse_en_d;
            chan_a_hit_count_out        <= hit_a_d;
            chan_a_enable_out           <= hit_a_en_d;
            chan_b_hit_count_out        <= hit_b_d;
            chan_b_enable_out           <= hit_b_en_d;
            fast_init_out               <= fast_init_d;
        end
    end

endmodule // tmc_config_regs

//--- rtl/tmc_defines.vh
// Offsets, field positions, reset values and timing counts of the
// configuration bank. Assumes a 200 MHz system clock.
`ifndef TMC_DEFINES_VH
`define TMC_DEFINES_VH
`define TMC_ADDR_W          4
`define TMC_OFS_SETUP       4'h0
`define TMC_OFS_HITS        4'h4
`define TMC_OFS_STATUS      4'h8
`define TMC_SETUP_RST       24'h00_0668
`define TMC_SETUP_RST_LO    24'h00_0668
`define TMC_HITS_RST        24'h55_4000
`define TMC_B_START_INV     0
`define TMC_B_STOPA_INV     1
`define TMC_B_STOPB_INV     2
`define TMC_B_RANGE2        3
`define TMC_B_ACAL_DIS      4
`define TMC_B_CAL_EN        5
`define TMC_B_TCLK_SEL      6
`define TMC_B_DUMMY         7
`define TMC_B_TEMP_CYCLE_TIME        8
`define TMC_B_PORTS         9
`define TMC_F_OSC_LO        10
`define TMC_F_DIV_LO        12
`define TMC_F_RESONATOR_CAL_PERIODS_LO     14
`define TMC_F_PDIV_LO       16
`define TMC_F_PCNT_LO       20
`define TMC_F_HITA_LO       8
`define TMC_F_HITB_LO       11
`define TMC_B_FAST_INIT     15
`define TMC_DUMMY_SHORT     3'h2
`define TMC_DUMMY_LONG      3'h7
`define TMC_TCLK_HS_PER     8'h80
`define TMC_TCYC_SHORT_US   10'h080
`define TMC_TCYC_LONG_US    10'h200
`define TMC_SETTLE_SHORT_US 640
`define TMC_SETTLE_LONG_US  1280
`define TMC_CLK_MHZ         200
`define TMC_SETTLE_SHORT_CYC (`TMC_SETTLE_SHORT_US * `TMC_CLK_MHZ)
`define TMC_SETTLE_LONG_CYC  (`TMC_SETTLE_LONG_US * `TMC_CLK_MHZ)
`define TMC_OSC_OFF         2'h0
`define TMC_OSC_ON          2'h1
`define TMC_OSC_SETTLE_S    2'h2
`define TMC_OSC_SETTLE_L    2'h3
`endif

//--- tb/tmc_config_chk.sv
// Checker for the configuration bank: relations among decoded outputs.
// Assumes a bind to tmc_config_regs and its single clock.
`timescale 1ns/1ps
module tmc_config_chk (
    input wire       sys_clk_in,
    input wire       resetn_in,
    input wire       meas_start_in,
    input wire       range_two_select_out,
    input wire       cal_calc_enable_out,
    input wire [7:0] temp_clk_hs_periods_out,
    input wire [2:0] dummy_cycles_out,
    input wire [9:0] temp_cycle_time_us_out,
    input wire [2:0] fast_clock_prediv_out,
    input wire [3:0] pulse_count_out,
    input wire       pulse_gen_enable_out,
    input wire [2:0] chan_a_hit_count_out,
    input wire       chan_a_enable_out,
    input wire [2:0] chan_b_hit_count_out,
    input wire       chan_b_enable_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    hs_periods_a: assert property (temp_clk_hs_periods_out == 8'h80)
        else $error("fast period count wrong");
    dummy_count_a: assert property (dummy_cycles_out == 3'h2 ||
        dummy_cycles_out == 3'h7) else $error("dummy count wrong");
    cycle_time_a: assert property (temp_cycle_time_us_out == 10'h080 ||
        temp_cycle_time_us_out == 10'h200) else $error("cycle time wrong");
    clk_prediv_a: assert property (fast_clock_prediv_out inside
        {3'h1, 3'h2, 3'h4}) else $error("fast predivide wrong");
    cal_keep_a: assert property (range_two_select_out |->
        cal_calc_enable_out) else $error("calibration off in range two");
    pulse_gen_a: assert property (pulse_gen_enable_out ==
        (pulse_count_out != 4'h0)) else $error("pulse enable wrong");
    chan_a_en_a: assert property (chan_a_enable_out ==
        (chan_a_hit_count_out != 3'h0)) else $error("channel a enable wrong");
    chan_b_en_a: assert property (chan_b_enable_out ==
        (chan_b_hit_count_out != 3'h0)) else $error("channel b enable wrong");
    cfg_hold_a: assert property (!meas_start_in |=>
        $stable(range_two_select_out) && $stable(pulse_count_out))
        else $error("config changed without start");
    cover property (meas_start_in ##1 range_two_select_out);
    cover property (chan_b_enable_out);
    cover property (pulse_gen_enable_out);
endmodule // tmc_config_chk
bind tmc_config_regs tmc_config_chk i_chk (.sys_clk_in, .resetn_in,
    .meas_start_in, .range_two_select_out, .cal_calc_enable_out,
    .temp_clk_hs_periods_out, .dummy_cycles_out, .temp_cycle_time_us_out,
    .fast_clock_prediv_out, .pulse_count_out, .pulse_gen_enable_out,
    .chan_a_hit_count_out, .chan_a_enable_out, .chan_b_hit_count_out,
    .chan_b_enable_out);

//--- tb/tmc_config_regs_bench.sv
// Bench for the configuration bank: Avalon-MM writes, latching, status.
// Assumes short settle counts so the oscillator waits stay brief.
`timescale 1ns/1ps
`include "tmc_defines.vh"
module tmc_config_regs_bench;
    reg         sys_clk_in, resetn_in, meas_start_in, avs_read_in;
    reg         avs_write_in;
    reg  [3:0]  avs_address_in, k;
    reg  [31:0] avs_writedata_in, rd;
    reg  [23:0] w, prev;
    reg  [1:0]  rs;
    wire [31:0] rdata;
    wire [1:0]  resp, osc;
    wire        wreq;
    wire [29:0] g1;
    wire [16:0] g2;
    wire [8:0]  g3;
    integer     fail_count, tests_run, i;
    tmc_config_regs #(.SETTLE_SHORT_CYC(20), .SETTLE_LONG_CYC(40)) i_dut (
        .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .clk_en_in(1'b1),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(4'hF), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wreq), .avs_response_out(resp),
        .meas_start_in(meas_start_in), .start_edge_invert_out(g1[29]),
        .stop_a_edge_invert_out(g1[28]), .stop_b_edge_invert_out(g1[27]),
        .range_two_select_out(g1[26]), .auto_cal_run_out(g1[25]),
        .cal_calc_enable_out(g1[24]), .temp_cycle_clock_select_out(g1[23]),
        .four_ports_out(g1[22]), .pulse_gen_enable_out(g1[21]),
        .dummy_cycles_out(g1[20:18]), .temp_cycle_time_us_out(g1[17:8]),
        .fast_clock_prediv_out(g1[7:5]), .resonator_cal_periods_out(g1[4:0]),
        .pulse_prediv_out(g2[16:12]), .pulse_count_out(g2[11:8]),
        .temp_clk_hs_periods_out(g2[7:0]), .chan_a_hit_count_out(g3[8:6]),
        .chan_a_enable_out(g3[5]), .chan_b_hit_count_out(g3[4:2]),
        .chan_b_enable_out(g3[1]), .fast_init_out(g3[0]),
        .fast_osc_on_out(osc[1]), .fast_osc_ready_out(osc[0]));
    function [31:0] e1(input [23:0] v);
        e1 = {2'h0, v[0], v[1], v[2], v[3], !v[4], v[5] | v[3], v[6], v[9],
            v[23:20] != 4'h0, v[7] ? 3'h7 : 3'h2, v[8] ? 10'h200 : 10'h080,
            v[13] ? 3'h4 : (v[12] ? 3'h2 : 3'h1), 5'h02 << v[15:14]};
    endfunction
    function [31:0] e2(input [23:0] v);
        e2 = {15'h0, v[19:16] == 4'h0 ? 5'h02 : {1'b0, v[19:16]} + 5'h01,
            v[23:20], 8'h80};
    endfunction
    function [31:0] e3(input [23:0] v);
        e3 = {23'h0, v[10:8], v[10:8] != 3'h0, v[13:11], v[13:11] != 3'h0,
            v[15]};
    endfunction
    task stop_test;
        begin
            $display("checks %0d errors %0d", tests_run, fail_count);
            if (fail_count == 0 && tests_run > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // Request held until waitrequest is sampled low, released at that edge
    task bus(input wr, input [3:0] a, input [31:0] d);
        begin
            @(posedge sys_clk_in);
            avs_read_in <= !wr;
            avs_write_in <= wr;
            avs_address_in <= a;
            avs_writedata_in <= d;
            @(posedge sys_clk_in);
            while (wreq !== 1'b0) @(posedge sys_clk_in);
            rd = rdata;
            rs = resp;
            avs_read_in <= 1'b0;
            avs_write_in <= 1'b0;
        end
    endtask
    task meas;
        begin
            @(posedge sys_clk_in) meas_start_in <= 1'b1;
            @(posedge sys_clk_in) meas_start_in <= 1'b0;
            repeat (2) @(posedge sys_clk_in);
        end
    endtask
    initial begin
        sys_clk_in = 1'b0;
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end
    initial begin
        repeat (5000) @(posedge sys_clk_in);
        fail_count = fail_count + 1;
        stop_test;
    end
    initial begin
        {resetn_in, meas_start_in, avs_read_in, avs_write_in} = 4'h0;
        avs_address_in = 4'h0;
        avs_writedata_in = 32'h0;
        fail_count = 0;
        tests_run = 0;
        repeat (4) @(posedge sys_clk_in);
        resetn_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        chk({2'h0, g1}, e1(`TMC_SETUP_RST_LO));
        chk({30'h0, osc}, 32'h3);
        prev = `TMC_SETUP_RST;
        meas;
        chk({15'h0, g2}, e2(prev));
        chk({23'h0, g3}, e3(`TMC_HITS_RST));
        for (i = 0; i < 4; i = i + 1) begin
            k = i;
            w = {k * 4'h5, k * 4'h4 + 4'h1, k[1:0], k[1:0], 2'h1,
                i == 0 ? 10'h000 : i == 1 ? 10'h3FF : i == 2 ? 10'h2AA :
                10'h155};
            bus(1'b1, `TMC_OFS_SETUP, {8'h0, w});
            chk({2'h0, g1}, e1(prev));
            meas;
            chk({2'h0, g1}, e1(w));
            chk({15'h0, g2}, e2(w));
            prev = w;
        end
        // Calibration clear in range two and zero predivide are overridden in decode and flagged
        bus(1'b1, `TMC_OFS_SETUP, 32'h10_0408);
        meas;
        chk({2'h0, g1}, e1(24'h10_0408));
        chk({15'h0, g2}, e2(24'h10_0408));
        bus(1'b0, `TMC_OFS_STATUS, 32'h0);
        chk(rd & 32'h4, 32'h4);
        for (i = 0; i < 5; i = i + 1) begin
            k = i;
            w = {8'h0, k[0], 1'b0, 3'h4 - k[2:0], k[2:0], 8'h00};
            bus(1'b1, `TMC_OFS_HITS, {8'h0, w});
            meas;
            chk({23'h0, g3}, e3(w));
        end
        bus(1'b0, `TMC_OFS_STATUS, 32'h0);
        chk(rd & 32'h4, 32'h0);
        bus(1'b1, `TMC_OFS_HITS, 32'h00_0500);
        bus(1'b0, `TMC_OFS_STATUS, 32'h0);
        chk(rd & 32'h4, 32'h4);
        bus(1'b0, `TMC_OFS_SETUP, 32'h0);
        chk({rd[29:0], rs}, 32'h0);
        bus(1'b0, 4'hC, 32'h0);
        chk({30'h0, rs}, 32'h2);
        // Settle modes: ready drops on change, rises after the count
        bus(1'b1, `TMC_OFS_SETUP, 32'h00_0800);
        bus(1'b0, `TMC_OFS_STATUS, 32'h0);
        chk(rd & 32'h3, 32'h1);
        repeat (30) @(posedge sys_clk_in);
        chk({30'h0, osc}, 32'h3);
        bus(1'b1, `TMC_OFS_SETUP, 32'h00_0C00);
        repeat (30) @(posedge sys_clk_in);
        chk({30'h0, osc}, 32'h2);
        repeat (15) @(posedge sys_clk_in);
        chk({30'h0, osc}, 32'h3);
        bus(1'b1, `TMC_OFS_SETUP, 32'h0);
        repeat (3) @(posedge sys_clk_in);
        chk({30'h0, osc}, 32'h0);
        // Mid-run reset brings back both default words
        resetn_in <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        resetn_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        chk({2'h0, g1}, e1(`TMC_SETUP_RST));
        chk({30'h0, osc}, 32'h3);
        meas;
        chk({2'h0, g1}, e1(`TMC_SETUP_RST));
        chk({15'h0, g2}, e2(`TMC_SETUP_RST));
        chk({23'h0, g3}, e3(`TMC_HITS_RST));
        stop_test;
    end
endmodule // tmc_config_regs_bench
